// file: sim/tbd_buzzer.sv
// buzzer model that times the half periods of the pulse pin
`timescale 1ns/100ps

module tbd_buzzer (
  // clock and pin
  input wire logic clk,
  input wire logic pulse_output_n,
  // measurement
  output int half_len,
  output int edges
);
  int cnt = 0;
  logic last = 1'b1;
  // latch set high before the shared pin turns to output
  logic port1_latch = 1'b1;
  logic port1_direction = 1'b0;
  logic pad;

  initial @(negedge clk) port1_direction = 1'b1;
  // pad idles high until the pin is an output
  assign pad = port1_direction ? (pulse_output_n & port1_latch) : 1'b1;

  always @(negedge clk) begin
    cnt++;
    if (pad !== last) begin
      half_len <= cnt;
      edges <= edges + 1;
      cnt = 0;
    end
    last = pad;
  end
endmodule

// file: sim/tbd_time_base_test.sv
// self-checking bench for the time base and pulse output block
`timescale 1ns/100ps

module tbd_time_base_test;
  import tbd_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic halving_select = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq, pin;
  logic irq_l = 1'b0;
  logic [1:0] bresp, rresp;
  int half_len, edges, failures = 0, samples_checked = 0, cyc = 0, ic = 0, seed = 2;
  logic [33:0] bq[$], rq[$], iq[$], hq[$];
  int per_n[8] = '{23, 21, 16, 14, 13, 12, 11, 9};
  localparam logic [31:0] CTRL = 32'({TBD_CTRL_IDX, 2'b00});
  localparam logic [31:0] STAT = 32'({TBD_STAT_IDX, 2'b00});
  localparam logic [31:0] MSK = 32'({TBD_MASK_IDX, 2'b00});
  localparam logic [31:0] BAD = 32'h0000_00e4;

  initial forever #25 clk = ~clk;

  tbd_time_base DUT (.clk(clk), .sys_rst(sys_rst), .halving_select(halving_select),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .periodic_timer_irq(irq), .pulse_output_n(pin));

  tbd_buzzer buzzer (.clk(clk), .pulse_output_n(pin), .half_len(half_len), .edges(edges));

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (e !== g) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    bq.push_back(34'(r));
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (arready !== 1'b1) @(posedge clk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // output watchers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (bvalid === 1'b1 && bready) chk("bresp", bq.pop_front(), 34'(bresp));
    if (rvalid === 1'b1 && rready) chk("read", rq.pop_front(), {rresp, rdata});
    if (cyc > 95000) begin
      failures++;
      give_verdict();
    end
  end

  always @(negedge clk) begin
    ic++;
    if (irq === 1'b1 && irq_l === 1'b0) begin
      if (iq.size() > 0) chk("irq interval", iq.pop_front(), 34'(ic));
      ic = 0;
    end
    irq_l = irq;
  end

  always @(edges) begin
    if (hq.size() > 0) chk("half period", hq.pop_front(), 34'(half_len));
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int e;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(CTRL, 32'h0000_0000, TBD_RESP_OKAY);
    rd(STAT, 32'h0000_0000, TBD_RESP_OKAY);
    rd(MSK, 32'h0000_0000, TBD_RESP_OKAY);
    chk("pin idle", 34'h1, 34'(pin));
    wr(CTRL, 32'h0000_0067, TBD_RESP_OKAY);
    rd(CTRL, 32'h0000_0067, TBD_RESP_OKAY);
    // lane 0 strobe off leaves the control register alone
    wstrb <= 4'he;
    wr(CTRL, 32'h0000_0080, TBD_RESP_OKAY);
    wstrb <= 4'hf;
    rd(CTRL, 32'h0000_0067, TBD_RESP_OKAY);
    wr(CTRL, 32'h0000_0002, TBD_RESP_OKAY);
    wr(BAD, 32'h0000_0001, TBD_RESP_SLVERR);
    rd(BAD, 32'h0000_0000, TBD_RESP_SLVERR);
    wr(MSK, 32'h0000_0001, TBD_RESP_OKAY);
    rd(MSK, 32'h0000_0001, TBD_RESP_OKAY);
    for (int c = 4; c < 8; c++) begin
      wr(CTRL, 32'(c) | 32'h0000_0008, TBD_RESP_OKAY);
      while (irq !== 1'b1) @(posedge clk);
      iq.push_back(34'h1 << per_n[c]);
      wr(STAT, 32'h0000_0001, TBD_RESP_OKAY);
      while (irq !== 1'b1) @(posedge clk);
      wr(CTRL, 32'(c), TBD_RESP_OKAY);
      wr(STAT, 32'h0000_0001, TBD_RESP_OKAY);
    end
    // masked event stays off the interrupt line
    wr(MSK, 32'h0000_0000, TBD_RESP_OKAY);
    wr(CTRL, 32'h0000_000f, TBD_RESP_OKAY);
    repeat (600) @(posedge clk);
    wr(CTRL, 32'h0000_0007, TBD_RESP_OKAY);
    rd(STAT, 32'h0000_0001, TBD_RESP_OKAY);
    chk("masked irq", 34'h0, 34'(irq));
    wr(STAT, 32'h0000_0001, TBD_RESP_OKAY);
    rd(STAT, 32'h0000_0000, TBD_RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      halving_select <= (c == 3) ? 1'b1 : 1'($random(seed));
      wr(CTRL, (32'(c) << 5) | 32'h0000_0007, TBD_RESP_OKAY);
      wr(CTRL, (32'(c) << 5) | 32'h0000_0087, TBD_RESP_OKAY);
      e = edges;
      while (edges < e + 2) @(posedge clk);
      hq.push_back(34'h1 << (12 - c + int'(halving_select)));
      e = edges;
      while (edges < e + 1) @(posedge clk);
      wr(CTRL, (32'(c) << 5) | 32'h0000_0007, TBD_RESP_OKAY);
    end
    repeat (3) @(posedge clk);
    chk("pin idle", 34'h1, 34'(pin));
    give_verdict();
  end
endmodule

// file: src/tbd_pkg.sv
// constants and types for the time base and pulse output block
package tbd_pkg;

  // ---------------------------------------------------------------
  // register map (indices, byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] TBD_CTRL_IDX = 12'h0036;
  localparam logic [11:0] TBD_STAT_IDX = 12'h0037;
  localparam logic [11:0] TBD_MASK_IDX = 12'h0038;
  localparam int unsigned TBD_AW = 12;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int unsigned TBD_PULSE_EN_BIT = 7;
  localparam int unsigned TBD_PULSE_RATE_HI = 6;
  localparam int unsigned TBD_PULSE_RATE_LO = 5;
  localparam int unsigned TBD_RSVD_BIT = 4;
  localparam int unsigned TBD_PER_EN_BIT = 3;
  localparam int unsigned TBD_PER_RATE_HI = 2;
  localparam int unsigned TBD_PER_RATE_LO = 0;
  localparam logic [7:0] TBD_CTRL_RST = 8'h00;
  localparam logic [7:0] TBD_CTRL_WMASK = 8'hef;
  localparam logic [0:0] TBD_STAT_RST = 1'h0;
  localparam logic [0:0] TBD_MASK_RST = 1'h0;

  // ---------------------------------------------------------------
  // divider taps: exponent n of fc/2^n, index 0 is code 0
  // ---------------------------------------------------------------
  localparam int unsigned TBD_DIV_W = 25;
  localparam logic [7:0][4:0] TBD_PER_EXP = {
    5'd9, 5'd11, 5'd12, 5'd13, 5'd14, 5'd16, 5'd21, 5'd23};
  localparam logic [3:0][4:0] TBD_PULSE_EXP = {5'd10, 5'd11, 5'd12, 5'd13};

  // ---------------------------------------------------------------
  // bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] TBD_RESP_OKAY = 2'h0;
  localparam logic [1:0] TBD_RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // complete block state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [TBD_DIV_W-1:0] div;
    logic [7:0] ctrl;
    logic [0:0] status;
    logic [0:0] mask;
    logic per_tap_d;
    logic per_en_d;
    logic pulse_n;
    logic irq;
    logic aw_got;
    logic [TBD_AW-1:0] aw_idx;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tbd_state_s;

endpackage

// file: src/tbd_time_base.sv
// time base periodic interrupt and divider pulse output with axi4-lite registers
//
// Operation
// RULE1: once enabled, a periodic interrupt event is raised on each falling edge of the selected tap.
// RULE2: a control write never clears the shared divider, so the first event may come early.
// RULE3: software changes the periodic rate only while that timer is disabled, not while disabling.
// RULE4: one write may set the periodic rate and enable together; the new rate applies from then.
// RULE5: periodic rate codes 0..7 pick fc/2^23, 2^21, 2^16, 2^14, 2^13, 2^12, 2^11, 2^9.
// RULE6: the control register is 8 bits: pulse enable, pulse rate, reserved, periodic enable, rate.
// RULE7: software always writes zero to control bit 4.
// RULE8: reset clears all eight control bits.
// RULE9: when enabled the active-low pulse pin carries a square wave of about half duty from its tap.
// RULE10: bit 7 enables the pulse output and bits 6..5 pick fc/2^13, 2^12, 2^11, 2^10.
// RULE11: software changes the pulse rate only while the pulse output is disabled.
// RULE12: software sets the port latch to 1 and then the pin to output before using the pulse.
// RULE13: with halving select high every tap moves one divider stage down, halving its frequency.
// RULE14: the divider is a free-running binary counter on fc, cleared only by system reset.
// RULE15: halving select is a static level input owned by the clock control logic.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps

module tbd_time_base (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // clock control
  input wire logic halving_select,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // outputs
  output logic periodic_timer_irq,
  output logic pulse_output_n
);
  import tbd_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tbd_state_s st_r;
  tbd_state_s st_nxt;

  logic [2:0] per_rate_sel;
  logic [1:0] pulse_rate_sel;
  logic periodic_timer_en;
  logic pulse_out_en;
  logic [4:0] per_idx;
  logic [4:0] pulse_idx;
  logic per_tap;
  logic pulse_tap;
  logic per_evt;
  logic wr_fire;
  logic [TBD_AW-1:0] ar_idx;
  logic [0:0] stat_clr;
  logic wr_ok;

  assign per_rate_sel = st_r.ctrl[TBD_PER_RATE_HI:TBD_PER_RATE_LO];
  assign pulse_rate_sel = st_r.ctrl[TBD_PULSE_RATE_HI:TBD_PULSE_RATE_LO];
  assign periodic_timer_en = st_r.ctrl[TBD_PER_EN_BIT];
  assign pulse_out_en = st_r.ctrl[TBD_PULSE_EN_BIT];

  // ---------------------------------------------------------------
  // tap selection
  // ---------------------------------------------------------------
  // RULE5 RULE13 tap index
  function automatic logic [4:0] tap_index(input logic [4:0] expo, input logic half);
    return expo - 5'd1 + {4'd0, half};
  endfunction

  // RULE15 halving select used as a plain level
  // RULE10 RULE13 pulse tap
  assign per_idx = tap_index(TBD_PER_EXP[per_rate_sel], halving_select);
  assign pulse_idx = tap_index(TBD_PULSE_EXP[pulse_rate_sel], halving_select);
  assign per_tap = st_r.div[per_idx];
  assign pulse_tap = st_r.div[pulse_idx];

  // RULE1 RULE4 falling edge, only after a full enabled cycle
  assign per_evt = periodic_timer_en & st_r.per_en_d & st_r.per_tap_d & ~per_tap;

  // ---------------------------------------------------------------
  // bus decode helpers
  // ---------------------------------------------------------------
  assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
  assign ar_idx = s_axi_araddr[TBD_AW+1:2];
  assign wr_ok = (st_r.aw_idx == TBD_CTRL_IDX) || (st_r.aw_idx == TBD_STAT_IDX) ||
                 (st_r.aw_idx == TBD_MASK_IDX);

  always_comb begin
    stat_clr = 1'b0;
    if (wr_fire && st_r.aw_idx == TBD_STAT_IDX && st_r.wstrb[0]) begin
      stat_clr = st_r.wdata[0:0];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // RULE14 RULE2 free-running divider, untouched by writes
    st_nxt.div = st_r.div + {{(TBD_DIV_W-1){1'b0}}, 1'b1};
    st_nxt.per_tap_d = per_tap;
    st_nxt.per_en_d = periodic_timer_en;

    // RULE9 square wave on the active-low pin, idle high
    st_nxt.pulse_n = pulse_out_en ? ~pulse_tap : 1'b1;

    // write address and data, either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[TBD_AW+1:2];
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end

    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = wr_ok ? TBD_RESP_OKAY : TBD_RESP_SLVERR;
      if (st_r.aw_idx == TBD_CTRL_IDX) begin
        if (st_r.wstrb[0]) begin
          // RULE6 RULE4 reserved bit stays zero, rate and enable in one write
          st_nxt.ctrl = st_r.wdata[7:0] & TBD_CTRL_WMASK;
        end
      end else if (st_r.aw_idx == TBD_MASK_IDX) begin
        if (st_r.wstrb[0]) begin
          st_nxt.mask = st_r.wdata[0:0];
        end
      end
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // RULE1 sticky event, set wins over clear
    st_nxt.status = (st_r.status & ~stat_clr) | per_evt;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);

    st_nxt.awready = ~st_nxt.aw_got & ~st_nxt.bvalid;
    st_nxt.wready = ~st_nxt.w_got & ~st_nxt.bvalid;

    // read channel
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = TBD_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      if (ar_idx == TBD_CTRL_IDX) begin
        st_nxt.rdata = {24'h00_0000, st_r.ctrl};
      end else if (ar_idx == TBD_STAT_IDX) begin
        st_nxt.rdata = {31'h0000_0000, st_r.status};
      end else if (ar_idx == TBD_MASK_IDX) begin
        st_nxt.rdata = {31'h0000_0000, st_r.mask};
      end else begin
        st_nxt.rresp = TBD_RESP_SLVERR;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      // RULE8 control cleared
      st_r.ctrl <= TBD_CTRL_RST;
      st_r.status <= TBD_STAT_RST;
      st_r.mask <= TBD_MASK_RST;
      st_r.pulse_n <= 1'b1;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.bresp <= TBD_RESP_OKAY;
      st_r.rresp <= TBD_RESP_OKAY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign periodic_timer_irq = st_r.irq;
  assign pulse_output_n = st_r.pulse_n;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_tap_fall;
    st_r.per_tap_d && !per_tap;
  endsequence

  sequence s_enabled_two;
    periodic_timer_en && st_r.per_en_d;
  endsequence

  property p_evt_on_fall;
    @(posedge clk) disable iff (sys_rst)
      (s_enabled_two and s_tap_fall) |=> st_r.status[0] && periodic_timer_irq == st_r.mask[0];
  endproperty
  a_evt_on_fall: assert property (p_evt_on_fall) else $error("missed periodic event"); // RULE1

  property p_div_free;
    @(posedge clk) disable iff (sys_rst)
      !$past(sys_rst) |-> st_r.div == $past(st_r.div) + {{(TBD_DIV_W-1){1'b0}}, 1'b1};
  endproperty
  a_div_free: assert property (p_div_free) else $error("divider not free running"); // RULE2

  property p_evt_needs_en;
    @(posedge clk) disable iff (sys_rst)
      per_evt |-> $past(periodic_timer_en) && periodic_timer_en;
  endproperty
  a_evt_needs_en: assert property (p_evt_needs_en) else $error("event without enable"); // RULE4

  property p_per_tap;
    @(posedge clk) disable iff (sys_rst)
      (per_rate_sel == 3'h2 && !halving_select) |-> per_tap == st_r.div[15];
  endproperty
  a_per_tap: assert property (p_per_tap) else $error("periodic tap wrong"); // RULE5

  property p_rsvd_zero;
    @(posedge clk) disable iff (sys_rst)
      st_r.ctrl[TBD_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // RULE6

  property p_reset_ctrl;
    @(posedge clk) sys_rst |=> st_r.ctrl == TBD_CTRL_RST && pulse_output_n;
  endproperty
  a_reset_ctrl: assert property (p_reset_ctrl) else $error("control not cleared"); // RULE8

  property p_pulse_wave;
    @(posedge clk) disable iff (sys_rst)
      pulse_out_en |=> pulse_output_n == !$past(pulse_tap);
  endproperty
  a_pulse_wave: assert property (p_pulse_wave) else $error("pulse pin wrong"); // RULE9

  property p_pulse_off;
    @(posedge clk) disable iff (sys_rst)
      !pulse_out_en [*2] |-> pulse_output_n;
  endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("pulse pin active"); // RULE10

  property p_halved;
    @(posedge clk) disable iff (sys_rst)
      (halving_select && per_rate_sel == 3'h7 && pulse_rate_sel == 2'h3) |->
        per_tap == st_r.div[9] && pulse_tap == st_r.div[10];
  endproperty
  a_halved: assert property (p_halved) else $error("halved tap wrong"); // RULE13

  property p_pulse_tap;
    @(posedge clk) disable iff (sys_rst)
      (pulse_rate_sel == 2'h0 && !halving_select) |-> pulse_tap == st_r.div[12];
  endproperty
  a_pulse_tap: assert property (p_pulse_tap) else $error("pulse tap wrong"); // RULE10

  property p_status_sticky;
    @(posedge clk) disable iff (sys_rst)
      (st_r.status[0] && !stat_clr[0]) |=> st_r.status[0];
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit lost"); // RULE1

  property p_no_evt_off;
    @(posedge clk) disable iff (sys_rst)
      (!periodic_timer_en && !st_r.status[0]) |=> !st_r.status[0];
  endproperty
  a_no_evt_off: assert property (p_no_evt_off) else $error("event while disabled"); // RULE1

  property p_ctrl_stable;
    @(posedge clk) disable iff (sys_rst)
      !(wr_fire && st_r.aw_idx == TBD_CTRL_IDX) |=> $stable(st_r.ctrl);
  endproperty
  a_ctrl_stable: assert property (p_ctrl_stable) else $error("control changed"); // RULE6

  property p_reset_bus;
    @(posedge clk) sys_rst |=> s_axi_awready && s_axi_wready && s_axi_arready &&
      !s_axi_bvalid && !s_axi_rvalid && !periodic_timer_irq;
  endproperty
  a_reset_bus: assert property (p_reset_bus) else $error("bus not idle after reset"); // RULE8

  // ---------------------------------------------------------------
  // bus checks
  // ---------------------------------------------------------------
  sequence s_wr_latched;
    st_r.aw_got && st_r.w_got && !st_r.bvalid;
  endsequence

  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  property p_wr_answer;
    @(posedge clk) disable iff (sys_rst)
      s_wr_latched |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");

  property p_rd_answer;
    @(posedge clk) disable iff (sys_rst)
      s_ar_taken |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_one_write;
    @(posedge clk) disable iff (sys_rst)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_one_write: assert property (p_one_write) else $error("write taken during response");

endmodule
